// >>> hw/crfe_pkg.sv
// package: shared constants for the cache range flush engine
package crfe_pkg;
  // =====================================================================
  // widths
  localparam int ADDR_W = 16;   // line index width (64B lines)
  localparam int REG_AW = 4;
  localparam int DATA_W = 32;
  // =====================================================================
  // register offsets (byte addresses, one word each)
  localparam logic [REG_AW-1:0] OFS_LOW = 4'h0;
  localparam logic [REG_AW-1:0] OFS_HIGH = 4'h4;
  localparam logic [REG_AW-1:0] OFS_POLICY = 4'h8;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'hc;
  // policy fields
  localparam int POL_EN_BIT = 0;
  localparam int POL_MODE_LSB = 1;
  localparam int POL_IRQ_EN_BIT = 3;
  // status fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ABORT_BIT = 1;
  localparam int ST_SF_OFF_BIT = 2;
  localparam int ST_PWR_BIT = 3;
  localparam int ST_BUSY_BIT = 4;
  // =====================================================================
  // flush modes (encoding also used as snoop type)
  localparam logic [1:0] MODE_CLEAN_INV = 2'h0;
  localparam logic [1:0] MODE_MAKE_INV = 2'h1;
  localparam logic [1:0] MODE_CLEAN_SHR = 2'h2;
  // power states
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_FULL = 2'h1;
  localparam logic [1:0] PWR_HALF = 2'h2;
  localparam logic [1:0] PWR_FILTER = 2'h3;
  // cache line states
  localparam logic [1:0] LN_I = 2'h0;
  localparam logic [1:0] LN_ES = 2'h1;
  localparam logic [1:0] LN_E = 2'h2;
  localparam logic [1:0] LN_M = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
endpackage

// >>> hw/crfe_link_if.sv
// interface: flush engine to snoop filter / system cache lookup port
`timescale 1ns/100ps
interface crfe_link_if;
  import crfe_pkg::*;
  logic req;
  logic is_slc;
  logic [ADDR_W-1:0] addr;
  logic [1:0] mode;
  logic rsp;
  logic hit;
  logic [1:0] state;
  logic act;
  logic [1:0] act_state;
  logic evict;
  modport engine (output req, output is_slc, output addr, output mode, output act, output act_state,
    output evict, input rsp, input hit, input state);
  modport cache (input req, input is_slc, input addr, input mode, input act, input act_state,
    input evict, output rsp, output hit, output state);
endinterface

// >>> hw/crfe_step.sv
// leaf: decides the action on one looked-up line
`timescale 1ns/100ps
module crfe_step
  import crfe_pkg::*;
(
  // lookup result
  input wire logic is_slc,
  input wire logic hit,
  input wire logic [1:0] state,
  input wire logic ocm,
  input wire logic [1:0] mode,
  // decision
  output logic act,
  output logic [1:0] next_state,
  output logic evict
);
  // one table covers both the filter and the system cache
  always_comb begin
    act = 1'b0;
    next_state = state;
    evict = 1'b0;
    if (!is_slc) begin
      act = hit; // snoop only on hit
      next_state = (mode == MODE_CLEAN_SHR) ? state : LN_I;
    end else if (state != LN_I) begin
      if (mode == MODE_MAKE_INV) begin
        act = 1'b1; // no writeback, ocm or not
        next_state = LN_I;
      end else if (!ocm) begin
        if (mode == MODE_CLEAN_INV) begin
          act = 1'b1;
          evict = (state == LN_M);
          next_state = LN_I;
        end else if (state == LN_M) begin
          act = 1'b1;
          evict = 1'b1;
          next_state = LN_E; // clean shared keeps exclusive copy
        end
      end
    end
  end
endmodule

// >>> hw/crfe_engine.sv
// device end: range flush engine with its register port
`timescale 1ns/100ps
// How it works
// - flush every line between low and high bounds
// - policy write starts flush, selects mode
// - set done bit, raise irq if enabled
// - done set on abort too, error bits differ
// - snoop filter pass before system cache pass
// - status cleared when next flush starts
// - completion message, irq after all nodes done
// - runs beside ordinary traffic, no ordering
// - power policy write aborts flush
// - flush only in steady supported power states
// - clean-invalid, make-invalid, clean-shared modes
// - filter hit snoops and updates; miss ignored
// - system cache eviction per mode table
// - on-chip memory lines kept for clean modes
// - disabled snoop filter aborts with error
// - software programs each node separately
// - software holds config while flush enabled
// - requesters avoid range during flush
module crfe_engine
  import crfe_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // power and system state
  input wire logic power_policy_wr,
  input wire logic [1:0] power_state,
  input wire logic power_in_transition,
  input wire logic filter_enabled,
  input wire logic ocm_enabled,
  input wire logic [ADDR_W-1:0] ocm_low,
  input wire logic [ADDR_W-1:0] ocm_high,
  input wire logic all_nodes_done,
  // completion
  output logic node_done_msg,
  output logic power_unit_irq,
  // cache lookup port
  crfe_link_if.engine link
);
  typedef enum logic [2:0] {CRFE_IDLE, CRFE_LOOK, CRFE_WAIT, CRFE_DONE, CRFE_IRQ} crfe_state_t;

  // =====================================================================
  // registers
  crfe_state_t st_reg, st_next;
  logic [ADDR_W-1:0] low_reg, low_next, high_reg, high_next, cur_reg, cur_next;
  logic [3:0] pol_reg, pol_next;
  logic [4:0] stat_reg, stat_next;
  logic slc_reg, slc_next;
  logic msg_reg, msg_next;
  logic irq_reg, irq_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic d_act, d_evict;
  logic [1:0] d_state;
  logic in_ocm, pwr_ok, start;

  assign in_ocm = ocm_enabled && cur_reg >= ocm_low && cur_reg <= ocm_high;
  assign pwr_ok = (power_state != PWR_OFF) && !power_in_transition;
  assign start = reg_wr && reg_addr == OFS_POLICY && reg_wdata[POL_EN_BIT];

  crfe_step u_step (
    .is_slc(slc_reg),
    .hit(link.hit),
    .state(link.state),
    .ocm(in_ocm),
    .mode(pol_reg[POL_MODE_LSB +: 2]),
    .act(d_act),
    .next_state(d_state),
    .evict(d_evict)
  );

  // lookup port drive; no lock against other traffic
  assign link.req = (st_reg == CRFE_LOOK);
  assign link.is_slc = slc_reg;
  assign link.addr = cur_reg;
  assign link.mode = pol_reg[POL_MODE_LSB +: 2]; // snoop type follows mode
  assign link.act = (st_reg == CRFE_WAIT) && link.rsp && d_act;
  assign link.act_state = d_state;
  assign link.evict = d_evict;
  assign reg_rdata = rdata_reg;
  assign node_done_msg = msg_reg;
  assign power_unit_irq = irq_reg;

  // =====================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    low_next = low_reg;
    high_next = high_reg;
    cur_next = cur_reg;
    pol_next = pol_reg;
    stat_next = stat_reg;
    slc_next = slc_reg;
    msg_next = 1'b0;
    irq_next = irq_reg;
    rdata_next = '0;
    // register reads: data stand the cycle after
    if (reg_rd) begin
      if (reg_addr == OFS_LOW) begin
        rdata_next[ADDR_W-1:0] = low_reg;
      end else if (reg_addr == OFS_HIGH) begin
        rdata_next[ADDR_W-1:0] = high_reg;
      end else if (reg_addr == OFS_POLICY) begin
        rdata_next[3:0] = pol_reg;
      end else if (reg_addr == OFS_STATUS) begin
        rdata_next[4:0] = stat_reg;
      end
    end
    // config writes; software keeps them still while busy
    if (reg_wr && reg_addr == OFS_LOW) begin
      low_next = reg_wdata[ADDR_W-1:0];
    end else if (reg_wr && reg_addr == OFS_HIGH) begin
      high_next = reg_wdata[ADDR_W-1:0];
    end else if (reg_wr && reg_addr == OFS_POLICY) begin
      pol_next = reg_wdata[3:0];
      if (reg_wdata[POL_MODE_LSB +: 2] == 2'h3) begin
        pol_next[POL_MODE_LSB +: 2] = MODE_CLEAN_INV; // unknown mode falls back to default
      end
    end
    case (st_reg)
      CRFE_IDLE: begin
        if (start) begin
          stat_next = '0;
          cur_next = reg_addr == OFS_POLICY ? low_reg : low_reg;
          slc_next = 1'b0; // filter first
          irq_next = 1'b0;
          if (!filter_enabled) begin
            stat_next[ST_ABORT_BIT] = 1'b1;
            stat_next[ST_SF_OFF_BIT] = 1'b1;
            st_next = CRFE_DONE;
          end else if (!pwr_ok) begin
            stat_next[ST_ABORT_BIT] = 1'b1;
            stat_next[ST_PWR_BIT] = 1'b1;
            st_next = CRFE_DONE;
          end else if (low_reg > high_reg) begin
            st_next = CRFE_DONE; // empty range
          end else begin
            stat_next[ST_BUSY_BIT] = 1'b1;
            st_next = CRFE_LOOK;
          end
        end
      end
      CRFE_LOOK: begin
        st_next = CRFE_WAIT;
      end
      CRFE_WAIT: begin
        if (link.rsp) begin
          if (cur_reg != high_reg) begin
            cur_next = cur_reg + ADDR_ONE; // walk whole range
            st_next = CRFE_LOOK;
          end else if (!slc_reg) begin
            slc_next = 1'b1; // system cache only after filter
            cur_next = low_reg;
            st_next = CRFE_LOOK;
          end else begin
            st_next = CRFE_DONE;
          end
        end
      end
      CRFE_DONE: begin
        stat_next[ST_BUSY_BIT] = 1'b0;
        stat_next[ST_DONE_BIT] = 1'b1; // set on abort too
        pol_next[POL_EN_BIT] = 1'b0;
        msg_next = 1'b1;
        st_next = CRFE_IRQ;
      end
      CRFE_IRQ: begin
        if (all_nodes_done) begin
          irq_next = pol_reg[POL_IRQ_EN_BIT]; // only once every node finished
          st_next = CRFE_IDLE;
        end else if (start) begin
          st_next = CRFE_IDLE;
        end
      end
      default: begin
        st_next = CRFE_IDLE;
      end
    endcase
    // power policy update wins over an active flush
    if (power_policy_wr && (st_reg == CRFE_LOOK || st_reg == CRFE_WAIT)) begin
      stat_next[ST_ABORT_BIT] = 1'b1;
      stat_next[ST_PWR_BIT] = 1'b1;
      st_next = CRFE_DONE;
    end
  end

  // =====================================================================
  // registering only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= CRFE_IDLE;
      low_reg <= '0;
      high_reg <= '0;
      cur_reg <= '0;
      pol_reg <= '0;
      stat_reg <= '0;
      slc_reg <= 1'b0;
      msg_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      low_reg <= low_next;
      high_reg <= high_next;
      cur_reg <= cur_next;
      pol_reg <= pol_next;
      stat_reg <= stat_next;
      slc_reg <= slc_next;
      msg_reg <= msg_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// >>> hw/crfe_cache.sv
// far end: snoop filter and system cache lookup with fixed latency
`timescale 1ns/100ps
module crfe_cache
  import crfe_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // lookup port
  crfe_link_if.cache link,
  // user side: preload and observe
  input wire logic load_wr,
  input wire logic load_slc,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [1:0] load_state,
  output logic snoop_valid,
  output logic [1:0] snoop_type,
  output logic [ADDR_W-1:0] snoop_addr,
  output logic wb_valid,
  output logic [ADDR_W-1:0] wb_addr
);
  localparam int DEPTH = 64;
  localparam int IW = 6;
  // =====================================================================
  // small direct arrays; address low bits index them
  logic [1:0] sf_mem [DEPTH];
  logic [1:0] slc_mem [DEPTH];
  logic rsp_reg, rsp_next;
  logic [1:0] st_reg, st_next;
  logic snp_reg, snp_next, wb_reg, wb_next;
  logic [1:0] styp_reg, styp_next;
  logic [ADDR_W-1:0] sadr_reg, sadr_next;
  logic [IW-1:0] idx;

  assign idx = link.addr[IW-1:0];
  assign link.rsp = rsp_reg;
  assign link.state = st_reg;
  assign link.hit = st_reg != LN_I;
  assign snoop_valid = snp_reg;
  assign snoop_type = styp_reg;
  assign snoop_addr = sadr_reg;
  assign wb_valid = wb_reg;
  assign wb_addr = sadr_reg;

  // =====================================================================
  // one-cycle lookup answer, action reported the cycle after
  always_comb begin
    rsp_next = link.req;
    st_next = link.is_slc ? slc_mem[idx] : sf_mem[idx];
    snp_next = link.act && !link.is_slc;
    wb_next = link.act && (link.evict || (!link.is_slc && link.mode != MODE_MAKE_INV));
    styp_next = link.mode;
    sadr_next = link.addr;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rsp_reg <= 1'b0;
      st_reg <= LN_I;
      snp_reg <= 1'b0;
      wb_reg <= 1'b0;
      styp_reg <= MODE_CLEAN_INV;
      sadr_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
      st_reg <= st_next;
      snp_reg <= snp_next;
      wb_reg <= wb_next;
      styp_reg <= styp_next;
      sadr_reg <= sadr_next;
    end
  end

  // array updates: flush action first, preload otherwise
  always_ff @(posedge mclk) begin
    if (link.act && link.is_slc) begin
      slc_mem[idx] <= link.act_state;
    end else if (link.act) begin
      sf_mem[idx] <= link.act_state;
    end else if (load_wr && load_slc) begin
      slc_mem[load_addr[IW-1:0]] <= load_state;
    end else if (load_wr) begin
      sf_mem[load_addr[IW-1:0]] <= load_state;
    end
  end
endmodule

// >>> test/crfe_chk.sv
// checker: timing and decision relations on the flush lookup link
`timescale 1ns/100ps
module crfe_chk
  import crfe_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // engine to cache
  input wire logic req,
  input wire logic is_slc,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] mode,
  input wire logic act,
  input wire logic [1:0] act_state,
  input wire logic evict,
  // cache to engine
  input wire logic rsp,
  input wire logic hit,
  input wire logic [1:0] state
);
  // =====================================================================
  // assertions, one clock domain
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_rsp_after_req: assert property (req |=> rsp)
    else $error("lookup answer missing");
  a_rsp_only_asked: assert property (rsp |-> $past(req))
    else $error("answer without lookup");
  a_act_in_rsp: assert property (act |-> rsp)
    else $error("action outside answer cycle");
  a_miss_stays_quiet: assert property (rsp && !hit |-> !act)
    else $error("action on a miss");
  a_mi_no_evict: assert property (act && is_slc && mode == MODE_MAKE_INV |-> !evict && act_state == LN_I)
    else $error("make invalid evicted or kept line");
  a_ci_evicts_m: assert property (act && is_slc && mode == MODE_CLEAN_INV |-> act_state == LN_I && evict == (state == LN_M))
    else $error("clean invalid decision wrong");
  a_cs_m_to_e: assert property (act && is_slc && mode == MODE_CLEAN_SHR |-> state == LN_M && evict && act_state == LN_E)
    else $error("clean shared decision wrong");
  a_addr_steps_one: assert property (req && $past(req, 2) && is_slc == $past(is_slc, 2) |-> addr == $past(addr, 2) + ADDR_ONE)
    else $error("line address skipped");
  a_mode_held: assert property (req && $past(req, 2) |-> mode == $past(mode, 2))
    else $error("mode changed mid walk");
  a_filter_first: assert property (req && !is_slc |-> !$past(req && is_slc, 2))
    else $error("filter lookup after cache pass");
  // main scenarios reached
  c_slc_evict: cover property (act && is_slc && evict);
  c_filter_snoop: cover property (act && !is_slc);
  c_miss: cover property (rsp && !hit);
  c_make_inv: cover property (act && mode == MODE_MAKE_INV);
endmodule

// >>> test/cache_range_flush_engine_bench.sv
// testbench: engine and cache ends joined by the lookup link
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module cache_range_flush_engine_bench;
  import crfe_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, power_policy_wr = 1'b0, power_in_transition = 1'b0;
  logic filter_enabled = 1'b1, ocm_enabled = 1'b0, all_nodes_done = 1'b0, load_wr = 1'b0, load_slc = 1'b0;
  logic [1:0] power_state = PWR_FULL, load_state = 2'h0, snoop_type, cur_mode;
  logic [ADDR_W-1:0] ocm_low = 16'h0, ocm_high = 16'h0, load_addr = 16'h0, snoop_addr, wb_addr;
  logic [DATA_W-1:0] reg_rdata, st;
  logic node_done_msg, power_unit_irq, snoop_valid, wb_valid;
  logic [1:0] fst [64];
  logic [1:0] sst [64];
  int num_errors = 0, checked = 0, n_snp, n_wb, n_msg, cyc = 0, last_snp, first_wb, tnum = 0;
  int cur_lo, cur_hi;
  // =====================================================================
  // design ends and checker
  crfe_link_if link();
  crfe_engine u_crfe_engine (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_policy_wr(power_policy_wr),
    .power_state(power_state), .power_in_transition(power_in_transition), .filter_enabled(filter_enabled),
    .ocm_enabled(ocm_enabled), .ocm_low(ocm_low), .ocm_high(ocm_high), .all_nodes_done(all_nodes_done),
    .node_done_msg(node_done_msg), .power_unit_irq(power_unit_irq), .link(link));
  crfe_cache u_crfe_cache (.mclk(mclk), .rst_n(rst_n), .link(link), .load_wr(load_wr), .load_slc(load_slc),
    .load_addr(load_addr), .load_state(load_state), .snoop_valid(snoop_valid), .snoop_type(snoop_type),
    .snoop_addr(snoop_addr), .wb_valid(wb_valid), .wb_addr(wb_addr));
  crfe_chk u_crfe_chk (.mclk(mclk), .rst_n(rst_n), .req(link.req), .is_slc(link.is_slc), .addr(link.addr),
    .mode(link.mode), .act(link.act), .act_state(link.act_state), .evict(link.evict), .rsp(link.rsp),
    .hit(link.hit), .state(link.state));
  // clock
  always #50 mclk = ~mclk;
  // observe outputs mid cycle, away from the launching edge
  always @(negedge mclk) begin
    cyc++;
    if (snoop_valid === 1'b1) begin
      n_snp++;
      last_snp = cyc;
      `CHK("snoop type", cur_mode, snoop_type)
      `CHK("snoop line", 1'b1, snoop_addr >= cur_lo && snoop_addr <= cur_hi)
      `CHK("snoop hit", 1'b1, fst[snoop_addr[5:0]] != LN_I)
      `CHK("snoop writeback", cur_mode != MODE_MAKE_INV, wb_valid)
    end
    // filter writebacks ride with their snoop; only system cache evictions counted here
    if (wb_valid === 1'b1 && snoop_valid !== 1'b1) begin
      n_wb++;
      if (first_wb == 0) first_wb = cyc;
      `CHK("evicted line", LN_M, sst[wb_addr[5:0]])
    end
    if (node_done_msg === 1'b1) n_msg++;
  end
  // =====================================================================
  // bus cycles
  task wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // random line states in both arrays, mirrored here
  task preload();
    for (int i = 0; i < 128; i++) begin
      @(posedge mclk);
      load_wr <= 1'b1;
      load_slc <= i[6];
      load_addr <= ADDR_W'(i % 64);
      load_state <= 2'($urandom_range(3, 0));
      #1 if (i < 64) fst[i] = load_state;
      else sst[i - 64] = load_state;
    end
    @(posedge mclk);
    load_wr <= 1'b0;
  endtask
  // expected filter snoops: every tracked line in range
  function automatic int exp_snoops(input int lo, input int hi);
    exp_snoops = 0;
    for (int i = lo; i <= hi; i++) exp_snoops += int'(fst[i] != LN_I);
  endfunction
  // expected system cache evictions: modified lines, clean modes, outside on-chip memory
  function automatic int exp_wbs(input int lo, input int hi);
    exp_wbs = 0;
    for (int i = lo; i <= hi; i++) exp_wbs += int'(sst[i] == LN_M && cur_mode != MODE_MAKE_INV && !ocm_enabled);
  endfunction
  // one flush from start to interrupt; pwr_at > 0 aborts it mid walk
  task flush(input logic [1:0] m, input int lo, input int hi, input logic [4:0] est, input int pwr_at);
    int es, ew;
    preload(); // no requester traffic during the walk
    cur_mode = (m == 2'h3) ? MODE_CLEAN_INV : m;
    cur_lo = lo;
    cur_hi = hi;
    es = exp_snoops(lo, hi);
    ew = exp_wbs(lo, hi);
    wr(OFS_LOW, 32'(lo));
    wr(OFS_HIGH, 32'(hi));
    n_snp = 0;
    n_wb = 0;
    n_msg = 0;
    first_wb = 0;
    last_snp = 0;
    wr(OFS_POLICY, {28'h0, 1'b1, m, 1'b1});
    // irq clears on the start edge; look once it has settled
    @(negedge mclk);
    `CHK("irq at start", 1'b0, power_unit_irq)
    repeat (pwr_at) @(posedge mclk);
    if (pwr_at > 0) power_policy_wr <= 1'b1;
    @(posedge mclk);
    power_policy_wr <= 1'b0;
    st = 32'h0;
    for (int k = 0; k < 400 && st[ST_DONE_BIT] !== 1'b1; k++) rd(OFS_STATUS, st); // config held
    `CHK("status", est, st[4:0])
    if (est == 5'h01) begin
      `CHK("snoops", es, n_snp)
      `CHK("writebacks", ew, n_wb)
      `CHK("filter first", 1'b1, ew == 0 || last_snp < first_wb)
      `CHK("node message", 1, n_msg)
    end
    `CHK("irq before all nodes", 1'b0, power_unit_irq)
    all_nodes_done <= 1'b1;
    for (int k = 0; k < 10 && power_unit_irq !== 1'b1; k++) @(posedge mclk);
    `CHK("irq", 1'b1, power_unit_irq)
    all_nodes_done <= 1'b0;
    tnum++;
    $display("test %0d ended", tnum);
  endtask
  // verdict
  task results();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // =====================================================================
  // hang guard: a dozen flushes take well under 40000 cycles
  initial begin
    #(100 * 60000);
    num_errors++;
    results();
  end
  initial begin
    int lo;
    void'($urandom(51));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h2, st);
    `CHK("unmapped read", 32'h0, st)
    wr(OFS_LOW, 32'h0000002a);
    rd(OFS_LOW, st);
    `CHK("low bound", 16'h002a, st[15:0])
    for (int m = 0; m < 4; m++) begin
      lo = int'($urandom_range(31, 0));
      power_state <= (m % 3 == 0) ? PWR_FULL : (m % 3 == 1) ? PWR_HALF : PWR_FILTER;
      flush(2'(m), lo, lo + int'($urandom_range(32, 0)), 5'h01, 0);
    end
    power_state <= PWR_FULL;
    flush(MODE_CLEAN_INV, 0, 63, 5'h01, 0);
    flush(MODE_CLEAN_SHR, 9, 8, 5'h01, 0);
    ocm_enabled <= 1'b1;
    ocm_high <= 16'hffff;
    flush(MODE_CLEAN_INV, 0, 63, 5'h01, 0);
    ocm_enabled <= 1'b0;
    filter_enabled <= 1'b0;
    flush(MODE_CLEAN_INV, 0, 63, 5'h07, 0);
    filter_enabled <= 1'b1;
    power_state <= PWR_OFF;
    flush(MODE_MAKE_INV, 0, 63, 5'h0b, 0);
    power_state <= PWR_FULL;
    power_in_transition <= 1'b1;
    flush(MODE_MAKE_INV, 0, 63, 5'h0b, 0);
    power_in_transition <= 1'b0;
    flush(MODE_CLEAN_INV, 0, 63, 5'h0b, 6);
    flush(MODE_MAKE_INV, 3, 40, 5'h01, 0);
    results();
  end
endmodule
